// File: shared/ies_pkg.sv
// constants, register map and carrier types of the enable, status and level block
// ==========================================================================
// How it works
// R1: enable resets off; off holds FIFOs erased
// R2: disable while busy winds down gracefully
// R3: disable flushes transmit and receive FIFOs
// R4: interrupt flags held until state machine idle
// R5: transmit finishes current transfer, drops rest
// R6: receive ends after byte, withholds acknowledge
// R7: enable change takes effect two cycles later
// R8: status bit 6 shows slave busy
// R9: status bit 5 shows master busy
// R10: status bit 4 shows receive FIFO full
// R11: status bit 3 shows receive FIFO nonempty
// R12: status bit 2 shows transmit FIFO empty
// R13: status bit 1 shows transmit FIFO not full
// R14: transmit level field bits 5 to 0
// R15: receive level field bits 5 to 0
// R16: status bit 0 shows any activity
// R17: sixteen bit data hold time, reset one
package ies_pkg;
	// ==========================================================================
	// bus and data widths
	localparam int ADDR_W = 32;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int LVL_W = 6;

	// ==========================================================================
	// register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_ON_OFF = 32'h5000136C;
	localparam logic [ADDR_W-1:0] ADDR_STATE_FLAGS = 32'h50001370;
	localparam logic [ADDR_W-1:0] ADDR_TX_FILL = 32'h50001374;
	localparam logic [ADDR_W-1:0] ADDR_RX_FILL = 32'h50001378;
	localparam logic [ADDR_W-1:0] ADDR_HOLD_TIME = 32'h5000137C;
	localparam logic [ADDR_W-1:0] ADDR_TX_DATA = 32'h500013A0;
	localparam logic [ADDR_W-1:0] ADDR_RX_DATA = 32'h500013A4;

	// ==========================================================================
	// field positions
	localparam int ON_BIT = 0;
	localparam int ST_TARGET_BUSY = 6;
	localparam int ST_INIT_BUSY = 5;
	localparam int ST_RX_FULL = 4;
	localparam int ST_RX_NONEMPTY = 3;
	localparam int ST_TX_EMPTY = 2;
	localparam int ST_TX_NOT_FULL = 1;
	localparam int ST_ACTIVITY = 0;

	// ==========================================================================
	// reset values
	localparam logic ON_RST = 1'b0;
	localparam logic [DATA_W-1:0] HOLD_RST = 16'h0001;
	localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;
	localparam int ON_LATENCY = 2;

	// ==========================================================================
	// carrier types
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wrData;
		logic wr;
		logic rd;
	} ies_bus_req_t;

	typedef struct packed {
		logic initiatorBusy;
		logic targetBusy;
		logic receiving;
	} ies_eng_stat_t;

	typedef struct packed {
		logic ctrlOn;
		logic stopReq;
		logic withholdAck;
		logic intrHold;
		logic intrRelease;
		logic [DATA_W-1:0] dataHold;
	} ies_eng_ctrl_t;

	typedef enum logic [1:0] {
		SD_OFF = 2'b00,
		SD_RUN = 2'b01,
		SD_STOP = 2'b11,
		SD_DONE = 2'b10
	} ies_sd_state_t;
endpackage : ies_pkg

// File: logic/ies_top.sv
// enable control, status, fill levels and data hold of the bus controller
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps

// ==========================================================================
// first-in first-out buffer with flush
module ies_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int LVLW = 6
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// erase all entries
	input wire logic flush,
	// filling side
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	// draining side
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady,
	// fill level
	output logic [LVLW-1:0] level
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [LVLW-1:0] FULL_CNT = LVLW'(DEPTH);
	localparam logic [LVLW-1:0] ZERO_CNT = '0;
	localparam logic [LVLW-1:0] ONE_CNT = LVLW'(1);

	if (DEPTH < 2 || DEPTH != (1 << AW) || DEPTH >= (1 << LVLW)) begin : gBadDepth
		$error("ies_fifo: depth must be a power of two that fits the level");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_ff;
	logic [AW-1:0] rdPtr_ff;
	logic [LVLW-1:0] count_ff;
	logic [LVLW-1:0] nxt_count;
	logic notFull_ff;
	logic notEmpty_ff;
	logic push;
	logic pop;

	assign push = inValid && notFull_ff && !flush;
	assign pop = notEmpty_ff && outReady && !flush;

	always_comb begin
		nxt_count = count_ff;
		if (flush) begin
			nxt_count = ZERO_CNT;
		end else if (push && !pop) begin
			nxt_count = count_ff + ONE_CNT;
		end else if (pop && !push) begin
			nxt_count = count_ff - ONE_CNT;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			count_ff <= ZERO_CNT;
			notFull_ff <= 1'b1;
			notEmpty_ff <= 1'b0;
		end else begin
			count_ff <= nxt_count;
			notFull_ff <= (nxt_count != FULL_CNT);
			notEmpty_ff <= (nxt_count != ZERO_CNT);
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n || flush) begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
		end else begin
			if (push) begin
				wrPtr_ff <= wrPtr_ff + AW'(1);
			end
			if (pop) begin
				rdPtr_ff <= rdPtr_ff + AW'(1);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wrPtr_ff] <= inData;
		end
	end

	assign inReady = notFull_ff;
	assign outValid = notEmpty_ff;
	assign outData = mem[rdPtr_ff];
	assign level = count_ff;
endmodule : ies_fifo

// ==========================================================================
// top: registers, enable pipeline, shutdown sequencing, queues
module ies_top #(
	parameter int DEPTH = ies_pkg::FIFO_DEPTH,
	parameter int WIDTH = ies_pkg::BYTE_W
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// register port
	input wire ies_pkg::ies_bus_req_t busReq,
	output logic [ies_pkg::DATA_W-1:0] rdData,
	// engine state
	input wire ies_pkg::ies_eng_stat_t engStat,
	// engine control
	output ies_pkg::ies_eng_ctrl_t engCtrl,
	// transmit stream to engine
	output logic txOutValid,
	output logic [WIDTH-1:0] txOutData,
	input wire logic txOutReady,
	// receive stream from engine
	input wire logic rxInValid,
	input wire logic [WIDTH-1:0] rxInData,
	output logic rxInReady
);
	import ies_pkg::*;

	if (WIDTH < 1 || WIDTH > DATA_W) begin : gBadWidth
		$error("ies_top: data width must fit the register port");
	end

	if (ON_LATENCY < 2) begin : gBadLatency
		$error("ies_top: enable latency must be at least two cycles");
	end

	if (DEPTH >= (1 << LVL_W)) begin : gBadLevel
		$error("ies_top: queue depth must fit the level fields");
	end

	if (LVL_W > DATA_W) begin : gBadLevelWidth
		$error("ies_top: level fields must fit the register port");
	end

	// ==========================================================================
	// declarations
	logic onReg_ff;
	logic [ON_LATENCY-2:0] onPipe_ff;
	logic ctrlOn_ff;
	logic [DATA_W-1:0] holdTime_ff;
	logic [DATA_W-1:0] rdData_ff;
	ies_sd_state_t sdState_ff;
	ies_sd_state_t nxt_sdState;
	logic stopReq_ff;
	logic withholdAck_ff;
	logic intrHold_ff;
	logic intrRelease_ff;
	logic flushQueues;
	logic engBusy;
	logic txPush;
	logic rxPop;
	logic txInReady;
	logic rxOutValid;
	logic [WIDTH-1:0] rxOutData;
	logic [LVL_W-1:0] txLevel;
	logic [LVL_W-1:0] rxLevel;
	logic txNotEmpty;
	logic [DATA_W-1:0] statusWord;

	assign engBusy = engStat.initiatorBusy || engStat.targetBusy;
	assign flushQueues = !ctrlOn_ff; // [R1] [R3]
	// writes while off or full are dropped
	assign txPush = busReq.wr && (busReq.addr == ADDR_TX_DATA) && ctrlOn_ff;
	// reading the receive data register pops the head
	assign rxPop = busReq.rd && (busReq.addr == ADDR_RX_DATA);

	// ==========================================================================
	// software settings
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			onReg_ff <= ON_RST; // [R1]
		end else if (busReq.wr && busReq.addr == ADDR_ON_OFF) begin
			onReg_ff <= busReq.wrData[ON_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			holdTime_ff <= HOLD_RST; // [R17]
		end else if (busReq.wr && busReq.addr == ADDR_HOLD_TIME) begin
			holdTime_ff <= busReq.wrData; // [R17]
		end
	end

	// ==========================================================================
	// enable pipeline
	// the enable flop itself is the last stage
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			onPipe_ff <= '0;
			ctrlOn_ff <= ON_RST;
		end else begin
			onPipe_ff <= (ON_LATENCY-1)'({onPipe_ff, onReg_ff}); // [R7]
			ctrlOn_ff <= onPipe_ff[ON_LATENCY-2]; // [R7]
		end
	end

	// ==========================================================================
	// shutdown sequencing
	always_comb begin
		nxt_sdState = sdState_ff;
		case (sdState_ff)
			SD_OFF: begin
				if (ctrlOn_ff) begin
					nxt_sdState = SD_RUN;
				end
			end
			SD_RUN: begin
				if (!ctrlOn_ff) begin
					nxt_sdState = engBusy ? SD_STOP : SD_DONE; // [R2]
				end
			end
			SD_STOP: begin
				if (!engBusy) begin
					nxt_sdState = SD_DONE; // [R4]
				end
			end
			SD_DONE: begin
				nxt_sdState = SD_OFF;
			end
			default: begin
				nxt_sdState = SD_OFF;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sdState_ff <= SD_OFF;
		end else begin
			sdState_ff <= nxt_sdState;
		end
	end

	// finish current transfer, then stop
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			stopReq_ff <= 1'b0;
		end else begin
			stopReq_ff <= (nxt_sdState == SD_STOP); // [R2] [R5]
		end
	end

	// no acknowledge for a byte still arriving
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			withholdAck_ff <= 1'b0;
		end else begin
			withholdAck_ff <= (nxt_sdState == SD_STOP) && engStat.receiving; // [R6]
		end
	end

	// interrupt flags kept until both engines idle
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			intrHold_ff <= 1'b0;
		end else begin
			intrHold_ff <= (nxt_sdState == SD_STOP); // [R4]
		end
	end

	// one-cycle release once wind-down is over
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			intrRelease_ff <= 1'b0;
		end else begin
			intrRelease_ff <= (nxt_sdState == SD_DONE); // [R4]
		end
	end

	// ==========================================================================
	// queues
	ies_fifo #(
		.WIDTH(WIDTH),
		.DEPTH(DEPTH),
		.LVLW(LVL_W)
	) uTxQueue (
		.mclk(mclk),
		.rst_n(rst_n),
		.flush(flushQueues), // [R5]
		.inValid(txPush),
		.inData(busReq.wrData[WIDTH-1:0]),
		.inReady(txInReady),
		.outValid(txNotEmpty),
		.outData(txOutData),
		.outReady(txOutReady),
		.level(txLevel)
	);

	ies_fifo #(
		.WIDTH(WIDTH),
		.DEPTH(DEPTH),
		.LVLW(LVL_W)
	) uRxQueue (
		.mclk(mclk),
		.rst_n(rst_n),
		.flush(flushQueues), // [R3]
		.inValid(rxInValid && ctrlOn_ff),
		.inData(rxInData),
		.inReady(rxInReady),
		.outValid(rxOutValid),
		.outData(rxOutData),
		.outReady(rxPop),
		.level(rxLevel)
	);

	assign txOutValid = txNotEmpty;

	// ==========================================================================
	// status word
	always_comb begin
		statusWord = READ_ZERO;
		statusWord[ST_TARGET_BUSY] = engStat.targetBusy; // [R8]
		statusWord[ST_INIT_BUSY] = engStat.initiatorBusy; // [R9]
		statusWord[ST_RX_FULL] = !rxInReady; // [R10]
		statusWord[ST_RX_NONEMPTY] = rxOutValid; // [R11]
		statusWord[ST_TX_EMPTY] = !txNotEmpty; // [R12]
		statusWord[ST_TX_NOT_FULL] = txInReady; // [R13]
		statusWord[ST_ACTIVITY] = engBusy; // [R16]
	end

	// ==========================================================================
	// read port
	// reserved bits and unmapped addresses read zero
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdData_ff <= READ_ZERO;
		end else if (busReq.rd) begin
			case (busReq.addr)
				ADDR_ON_OFF: begin
					rdData_ff <= {{(DATA_W-1){1'b0}}, onReg_ff};
				end
				ADDR_STATE_FLAGS: begin
					rdData_ff <= statusWord;
				end
				ADDR_TX_FILL: begin
					rdData_ff <= {{(DATA_W-LVL_W){1'b0}}, txLevel}; // [R14]
				end
				ADDR_RX_FILL: begin
					rdData_ff <= {{(DATA_W-LVL_W){1'b0}}, rxLevel}; // [R15]
				end
				ADDR_HOLD_TIME: begin
					rdData_ff <= holdTime_ff;
				end
				ADDR_RX_DATA: begin
					rdData_ff <= rxOutValid ? DATA_W'(rxOutData) : READ_ZERO;
				end
				default: begin
					rdData_ff <= READ_ZERO;
				end
			endcase
		end else begin
			rdData_ff <= READ_ZERO;
		end
	end

	assign rdData = rdData_ff;
	assign engCtrl = '{
		ctrlOn: ctrlOn_ff,
		stopReq: stopReq_ff,
		withholdAck: withholdAck_ff,
		intrHold: intrHold_ff,
		intrRelease: intrRelease_ff,
		dataHold: holdTime_ff
	};
endmodule : ies_top

// File: verif/ies_top_sva.sv
// assertions on the ports of the enable, status and level block
`timescale 1ns/1ps
module ies_top_sva #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// register port
	input wire ies_pkg::ies_bus_req_t busReq,
	input wire logic [ies_pkg::DATA_W-1:0] rdData,
	// engine
	input wire ies_pkg::ies_eng_stat_t engStat,
	input wire ies_pkg::ies_eng_ctrl_t engCtrl,
	// streams
	input wire logic txOutValid,
	input wire logic [WIDTH-1:0] txOutData,
	input wire logic txOutReady,
	input wire logic rxInValid,
	input wire logic [WIDTH-1:0] rxInData,
	input wire logic rxInReady
);
	import ies_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic busy;
	logic onWr;
	assign busy = engStat.initiatorBusy | engStat.targetBusy;
	assign onWr = busReq.wr && busReq.addr == ADDR_ON_OFF;
	// ==========
	// properties
	property p_status;
		busReq.rd && busReq.addr == ADDR_STATE_FLAGS |=> rdData[0] == $past(busy)
			&& rdData[15:5] == {9'h000, $past(engStat.targetBusy), $past(engStat.initiatorBusy)};
	endproperty
	a_status: assert property (p_status) else $error("activity bits wrong");
	property p_quiet;
		!busReq.rd |=> rdData == READ_ZERO;
	endproperty
	a_quiet: assert property (p_quiet) else $error("read data outside a read");
	property p_on;
		onWr && busReq.wrData[ON_BIT] && !engCtrl.ctrlOn |-> ##2 !engCtrl.ctrlOn ##1 engCtrl.ctrlOn;
	endproperty
	a_on: assert property (p_on) else $error("enable latency wrong");
	property p_off;
		onWr && !busReq.wrData[ON_BIT] && engCtrl.ctrlOn |-> ##2 engCtrl.ctrlOn ##1 !engCtrl.ctrlOn;
	endproperty
	a_off: assert property (p_off) else $error("disable latency wrong");
	property p_flush;
		!engCtrl.ctrlOn |=> !txOutValid && rxInReady;
	endproperty
	a_flush: assert property (p_flush) else $error("queue kept while off");
	property p_stop;
		$fell(engCtrl.ctrlOn) && busy |=> engCtrl.stopReq && engCtrl.intrHold
			&& engCtrl.withholdAck == $past(engStat.receiving);
	endproperty
	a_stop: assert property (p_stop) else $error("no wind-down when busy");
	property p_hold;
		engCtrl.stopReq && busy |=> engCtrl.stopReq && engCtrl.intrHold;
	endproperty
	a_hold: assert property (p_hold) else $error("wind-down ended while busy");
	property p_idle;
		$fell(engCtrl.ctrlOn) && !busy |-> ##[0:1] engCtrl.intrRelease;
	endproperty
	a_idle: assert property (p_idle) else $error("no release when idle");
	property p_pulse;
		engCtrl.intrRelease |=> !engCtrl.intrRelease;
	endproperty
	a_pulse: assert property (p_pulse) else $error("release not a pulse");
endmodule : ies_top_sva

bind ies_top ies_top_sva #(.WIDTH(WIDTH)) u_sva (.mclk(mclk), .rst_n(rst_n), .busReq(busReq),
	.rdData(rdData), .engStat(engStat), .engCtrl(engCtrl), .txOutValid(txOutValid),
	.txOutData(txOutData), .txOutReady(txOutReady), .rxInValid(rxInValid),
	.rxInData(rxInData), .rxInReady(rxInReady));

// File: verif/ies_engine_model.sv
// engine stand-in: pops transmit bytes, pushes counting receive bytes
`timescale 1ns/1ps
module ies_engine_model #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// bench control
	input wire logic popEn,
	input wire logic pushEn,
	// streams
	output logic txOutReady,
	output logic rxInValid,
	output logic [WIDTH-1:0] rxInData,
	input wire logic rxInReady
);
	logic [WIDTH-1:0] cnt_ff;
	assign txOutReady = popEn;
	assign rxInValid = pushEn;
	// idle data already moved past the last byte sent
	assign rxInData = cnt_ff;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cnt_ff <= '0;
		end else if (rxInValid && rxInReady) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end
endmodule : ies_engine_model

// File: verif/ies_top_bench.sv
// testbench of the enable, status and level block
`timescale 1ns/1ps
module ies_top_bench;
	import ies_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	ies_bus_req_t busReq = '0;
	ies_eng_stat_t engStat = '0;
	ies_eng_ctrl_t engCtrl;
	logic [DATA_W-1:0] rdData;
	logic txOutValid, txOutReady, rxInValid, rxInReady;
	logic [BYTE_W-1:0] txOutData, rxInData;
	logic popEn = 1'b0;
	logic pushEn = 1'b0;
	int miscompares = 0;
	int n_tests = 0;
	ies_top dut (.mclk(mclk), .rst_n(rst_n), .busReq(busReq), .rdData(rdData),
		.engStat(engStat), .engCtrl(engCtrl), .txOutValid(txOutValid), .txOutData(txOutData),
		.txOutReady(txOutReady), .rxInValid(rxInValid), .rxInData(rxInData),
		.rxInReady(rxInReady));
	ies_engine_model model (.mclk(mclk), .rst_n(rst_n), .popEn(popEn), .pushEn(pushEn),
		.txOutReady(txOutReady), .rxInValid(rxInValid), .rxInData(rxInData),
		.rxInReady(rxInReady));
	initial begin
		forever #20 mclk = ~mclk;
	end
	// ==========
	// tasks
	task automatic chk(input string what, input logic [DATA_W-1:0] exp, got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge mclk);
		busReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		busReq <= '0;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge mclk);
		busReq <= '{addr: a, wrData: '0, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		busReq <= '0;
		#1 chk($sformatf("reg %h", a), exp, rdData);
	endtask : rd
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict
	// ==========
	// tests
	initial begin
		cyc(6);
		rst_n <= 1'b1;
		rd(ADDR_ON_OFF, 16'h0000);
		rd(ADDR_STATE_FLAGS, 16'h0006);
		rd(ADDR_TX_FILL, 16'h0000);
		rd(ADDR_RX_FILL, 16'h0000);
		rd(ADDR_HOLD_TIME, 16'h0001);
		rd(32'h50001390, 16'h0000);
		wr(ADDR_HOLD_TIME, 16'hABCD);
		rd(ADDR_HOLD_TIME, 16'hABCD);
		chk("dataHold", 16'hABCD, engCtrl.dataHold);
		$display("reset test done");
		wr(ADDR_ON_OFF, 16'h0001);
		rd(ADDR_ON_OFF, 16'h0001);
		chk("ctrlOn", 16'h0001, 16'(engCtrl.ctrlOn));
		// engine stalled: last write refused
		for (int i = 0; i <= FIFO_DEPTH; i++) wr(ADDR_TX_DATA, 16'(i));
		rd(ADDR_TX_FILL, 16'h0010);
		rd(ADDR_STATE_FLAGS, 16'h0000);
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			chk("txOutData", 16'(i), 16'(txOutData));
			@(posedge mclk);
			popEn <= 1'b1;
			@(posedge mclk);
			popEn <= 1'b0;
			#1;
		end
		rd(ADDR_TX_FILL, 16'h0000);
		rd(ADDR_STATE_FLAGS, 16'h0006);
		$display("transmit test done");
		@(posedge mclk);
		pushEn <= 1'b1;
		cyc(20);
		pushEn <= 1'b0;
		rd(ADDR_RX_FILL, 16'h0010);
		rd(ADDR_STATE_FLAGS, 16'h001E);
		rd(ADDR_RX_DATA, 16'h0000);
		rd(ADDR_STATE_FLAGS, 16'h000E);
		for (int i = 1; i < FIFO_DEPTH; i++) rd(ADDR_RX_DATA, 16'(i));
		rd(ADDR_STATE_FLAGS, 16'h0006);
		$display("receive test done");
		@(posedge mclk);
		engStat <= '{initiatorBusy: 1'b0, targetBusy: 1'b1, receiving: 1'b0};
		rd(ADDR_STATE_FLAGS, 16'h0047);
		@(posedge mclk);
		engStat <= '{initiatorBusy: 1'b1, targetBusy: 1'b0, receiving: 1'b1};
		rd(ADDR_STATE_FLAGS, 16'h0027);
		wr(ADDR_TX_DATA, 16'h00A5);
		@(posedge mclk);
		pushEn <= 1'b1;
		@(posedge mclk);
		pushEn <= 1'b0;
		wr(ADDR_ON_OFF, 16'h0000);
		cyc(4);
		#1 chk("stopReq", 16'h0001, 16'(engCtrl.stopReq));
		chk("withholdAck", 16'h0001, 16'(engCtrl.withholdAck));
		chk("intrHold", 16'h0001, 16'(engCtrl.intrHold));
		rd(ADDR_TX_FILL, 16'h0000);
		rd(ADDR_RX_FILL, 16'h0000);
		@(posedge mclk);
		engStat <= '0;
		cyc(4);
		#1 chk("stopReq", 16'h0000, 16'(engCtrl.stopReq));
		chk("intrHold", 16'h0000, 16'(engCtrl.intrHold));
		wr(ADDR_ON_OFF, 16'h0001);
		cyc(4);
		wr(ADDR_ON_OFF, 16'h0000);
		cyc(4);
		wr(ADDR_TX_DATA, 16'h005A);
		rd(ADDR_TX_FILL, 16'h0000);
		$display("disable test done");
		print_verdict;
	end
	initial begin
		cyc(3000);
		miscompares++;
		print_verdict;
	end
endmodule : ies_top_bench
